// >>> rtl/link_ack_pkg.sv
package link_ack_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int ONE_SECOND_NS = 1_000_000_000;
  localparam int TICK_CYCLES_DEF = ONE_SECOND_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 25;

  localparam int PEERS = 16;
  localparam int PEER_W = 4;
  localparam int SLOTS = 4;
  localparam int SLOT_W = 2;
  localparam int ID_W = 8;
  localparam int LEN_W = 12;
  localparam int TMR_W = 11;
  localparam int NUM_TMR = 3;
  localparam int TMR_ACK = 0;
  localparam int TMR_BUSY = 1;
  localparam int TMR_TEST = 2;

  localparam logic [LEN_W-1:0] MIN_PDU_OCTETS = 12'h0009;
  localparam logic [LEN_W-1:0] PDU_OVERHEAD = 12'h0009;
  localparam logic [LEN_W-1:0] INFO_MIN = 12'h02C4;
  localparam logic [LEN_W-1:0] INFO_MAX = 12'h0D11;
  localparam logic [TMR_W-1:0] ACK_TMR_MIN = 11'h00A;
  localparam logic [TMR_W-1:0] ACK_TMR_MAX = 11'h708;
  localparam logic [TMR_W-1:0] ACK_TMR_RST = 11'h078;
  localparam logic [TMR_W-1:0] BUSY_TMR_RST = 11'h078;
  localparam logic [TMR_W-1:0] TEST_TTL_RST = 11'h000;
  localparam logic [LEN_W-1:0] INFO_RST = INFO_MAX;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MAX_INFO = 8'h04;
  localparam logic [7:0] OFS_BUSY_TMR = 8'h08;
  localparam logic [7:0] OFS_TEST_TTL = 8'h0C;
  localparam logic [7:0] OFS_ACK_TMR = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_PEER_BUSY = 8'h1C;
  localparam logic [7:0] OFS_SLOT_LOAD = 8'h20;
  localparam logic [7:0] OFS_SLOT_VIEW = 8'h24;

  localparam int CTRL_SILENT = 0;
  localparam int CTRL_USER_READY = 1;
  localparam int CTRL_NETWORK_CONTROL_STATION_LSB = 4;

  localparam int IRQ_W = 5;
  localparam int IRQ_ACK_TO = 0;
  localparam int IRQ_BUSY_TO = 1;
  localparam int IRQ_TEST_DROP = 2;
  localparam int IRQ_RETIRED = 3;
  localparam int IRQ_RX_BAD = 4;

  typedef enum logic [2:0] {
    RX_ACK_READY_RESP = 3'b000,
    RX_ACK_NOT_READY_RESP = 3'b001,
    RX_ACK_READY_CMD = 3'b010,
    RX_ACK_NOT_READY_CMD = 3'b011,
    RX_ACKED_BROADCAST_INFO = 3'b100,
    RX_CONNECTIONLESS_NOT_READY = 3'b101,
    RX_OTHER = 3'b110
  } rx_kind_type;
endpackage

// >>> rtl/link_ack_status.sv
`timescale 1ns/1ps
module link_ack_status #(
  parameter int TICK_CYCLES = link_ack_pkg::TICK_CYCLES_DEF
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  input wire logic rx_valid_i,
  input wire logic [2:0] rx_kind_i,
  input wire logic [link_ack_pkg::PEER_W-1:0] rx_src_i,
  input wire logic [link_ack_pkg::ID_W-1:0] rx_id_i,
  input wire logic [link_ack_pkg::LEN_W-1:0] rx_len_i,
  input wire logic local_busy_i,
  input wire logic not_ready_cmd_sent_i,
  input wire logic pdu_transmitted_i,
  input wire logic ack_received_i,
  input wire logic test_resp_queued_i,
  input wire logic test_resp_sent_i,
  output logic rx_accept_o,
  output logic tx_ready_pdu_o,
  output logic tx_not_ready_resp_o,
  output logic [link_ack_pkg::PEER_W-1:0] tx_dest_o,
  output logic [link_ack_pkg::PEERS-1:0] peer_busy_o,
  output logic [link_ack_pkg::PEER_W-1:0] network_control_station_o,
  output logic [link_ack_pkg::LEN_W-1:0] max_info_len_o,
  output logic [link_ack_pkg::SLOTS-1:0] pdu_retired_o,
  output logic ack_timeout_o,
  output logic busy_timeout_o,
  output logic test_resp_discard_o
);
  import link_ack_pkg::*;

  function automatic logic [LEN_W-1:0] clamp_info(input logic [LEN_W-1:0] v);
    clamp_info = (v < INFO_MIN) ? INFO_MIN : ((v > INFO_MAX) ? INFO_MAX : v);
  endfunction

  function automatic logic [TMR_W-1:0] clamp_ack(input logic [TMR_W-1:0] v);
    clamp_ack = (v < ACK_TMR_MIN) ? ACK_TMR_MIN : ((v > ACK_TMR_MAX) ? ACK_TMR_MAX : v);
  endfunction

  // bus slave
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic silent_q, silent_d;
  logic [PEER_W-1:0] network_control_station_q, network_control_station_d;
  logic [LEN_W-1:0] max_info_q, max_info_d;
  logic [TMR_W-1:0] busy_tmr_q, busy_tmr_d;
  logic [TMR_W-1:0] test_ttl_q, test_ttl_d;
  logic [TMR_W-1:0] ack_tmr_q, ack_tmr_d;
  logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic [SLOT_W-1:0] view_sel_q, view_sel_d;
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
  logic [PEERS-1:0] peer_busy_q, peer_busy_d;
  logic [SLOTS-1:0] slot_valid_q;
  logic [ID_W-1:0] slot_id_q [SLOTS];
  logic [PEERS-1:0] slot_dest_q [SLOTS];
  logic [SLOTS-1:0] retire_q;
  logic [NUM_TMR-1:0] tmr_exp_q;
  logic wr_en, rd_en, user_ready;
  logic slot_load;
  logic [SLOT_W-1:0] load_sel;

  // one wait cycle per access: read data are registered before waitrequest drops
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign wr_en = avs_write_i & ack_q;
  assign rd_en = avs_read_i & ~ack_q;
  assign user_ready = wr_en && avs_address_i == OFS_CTRL && avs_writedata_i[CTRL_USER_READY];
  assign slot_load = wr_en && avs_address_i == OFS_SLOT_LOAD;
  assign load_sel = avs_writedata_i[SLOT_W-1:0];

  always_comb begin
    ack_d = (avs_read_i | avs_write_i) & ~ack_q;
    rdata_d = rdata_q;
    silent_d = silent_q;
    network_control_station_d = network_control_station_q;
    max_info_d = max_info_q;
    busy_tmr_d = busy_tmr_q;
    test_ttl_d = test_ttl_q;
    ack_tmr_d = ack_tmr_q;
    irq_mask_d = irq_mask_q;
    view_sel_d = view_sel_q;
    if (rd_en) begin
      case (avs_address_i)
        OFS_CTRL: rdata_d = {24'h0000_00, network_control_station_q, 3'b000, silent_q};
        OFS_MAX_INFO: rdata_d = {20'h0_0000, max_info_q};
        OFS_BUSY_TMR: rdata_d = {21'h00_0000, busy_tmr_q};
        OFS_TEST_TTL: rdata_d = {21'h00_0000, test_ttl_q};
        OFS_ACK_TMR: rdata_d = {21'h00_0000, ack_tmr_q};
        OFS_IRQ_STATUS: rdata_d = {27'h000_0000, irq_stat_q};
        OFS_IRQ_MASK: rdata_d = {27'h000_0000, irq_mask_q};
        OFS_PEER_BUSY: rdata_d = {16'h0000, peer_busy_q};
        OFS_SLOT_LOAD: rdata_d = {28'h000_0000, slot_valid_q};
        OFS_SLOT_VIEW: rdata_d = {slot_dest_q[view_sel_q], slot_id_q[view_sel_q], 3'b000,
                                  slot_valid_q[view_sel_q], 2'b00, view_sel_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (wr_en) begin
      case (avs_address_i)
        OFS_CTRL: begin
          silent_d = avs_writedata_i[CTRL_SILENT];
          network_control_station_d = avs_writedata_i[CTRL_NETWORK_CONTROL_STATION_LSB +: PEER_W];
        end
        OFS_MAX_INFO: max_info_d = clamp_info(avs_writedata_i[LEN_W-1:0]);
        OFS_BUSY_TMR: busy_tmr_d = avs_writedata_i[TMR_W-1:0];
        OFS_TEST_TTL: test_ttl_d = avs_writedata_i[TMR_W-1:0];
        OFS_ACK_TMR: ack_tmr_d = clamp_ack(avs_writedata_i[TMR_W-1:0]);
        OFS_IRQ_MASK: irq_mask_d = avs_writedata_i[IRQ_W-1:0];
        OFS_SLOT_VIEW: view_sel_d = avs_writedata_i[SLOT_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      silent_q <= 1'b0;
      network_control_station_q <= '0;
      max_info_q <= INFO_RST;
      busy_tmr_q <= BUSY_TMR_RST;
      test_ttl_q <= TEST_TTL_RST;
      ack_tmr_q <= ACK_TMR_RST;
      irq_mask_q <= '0;
      view_sel_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      silent_q <= silent_d;
      network_control_station_q <= network_control_station_d;
      max_info_q <= max_info_d;
      busy_tmr_q <= busy_tmr_d;
      test_ttl_q <= test_ttl_d;
      ack_tmr_q <= ack_tmr_d;
      irq_mask_q <= irq_mask_d;
      view_sel_q <= view_sel_d;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign network_control_station_o = network_control_station_q;
  assign max_info_len_o = max_info_q;

  // receive classification
  logic rx_ok;
  logic [LEN_W-1:0] info_len;
  rx_kind_type kind;
  assign kind = rx_kind_type'(rx_kind_i);
  assign info_len = rx_len_i - PDU_OVERHEAD;
  // short frames and oversize information fields never reach the tables
  assign rx_ok = rx_valid_i && rx_len_i >= MIN_PDU_OCTETS && info_len <= max_info_q;
  assign rx_accept_o = rx_ok;

  // peer status and ready / not-ready generation
  logic sent_nr_q, sent_nr_d;
  logic busy_prev_q;
  logic tx_ready_q, tx_ready_d;
  logic tx_nr_q, tx_nr_d;
  logic [PEER_W-1:0] tx_dest_q, tx_dest_d;
  logic busy_start, busy_stop;

  always_comb begin
    peer_busy_d = peer_busy_q;
    // expiry clears first so that a same-cycle busy mark survives
    if (tmr_exp_q[TMR_BUSY]) begin
      peer_busy_d = '0;
    end
    sent_nr_d = sent_nr_q;
    tx_ready_d = 1'b0;
    tx_nr_d = 1'b0;
    tx_dest_d = tx_dest_q;
    busy_start = 1'b0;
    busy_stop = 1'b0;
    if (rx_ok && kind == RX_ACK_NOT_READY_CMD) begin
      peer_busy_d[rx_src_i] = 1'b1;
    end
    if (rx_ok && kind == RX_CONNECTIONLESS_NOT_READY) begin
      peer_busy_d[rx_src_i] = 1'b1;
      busy_start = 1'b1;
    end
    if (rx_ok && kind == RX_ACK_READY_CMD) begin
      peer_busy_d[rx_src_i] = 1'b0;
      busy_stop = 1'b1;
    end
    if (not_ready_cmd_sent_i) begin
      sent_nr_d = 1'b1;
    end
    if (!silent_q) begin
      if (busy_prev_q && !local_busy_i && sent_nr_q) begin
        tx_ready_d = 1'b1;
        sent_nr_d = 1'b0;
      end else if (rx_ok && kind == RX_ACKED_BROADCAST_INFO) begin
        tx_ready_d = !local_busy_i;
        tx_nr_d = local_busy_i && sent_nr_q;
        tx_dest_d = rx_src_i;
      end else if (user_ready) begin
        tx_ready_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      peer_busy_q <= '0;
      sent_nr_q <= 1'b0;
      busy_prev_q <= 1'b0;
      tx_ready_q <= 1'b0;
      tx_nr_q <= 1'b0;
      tx_dest_q <= '0;
    end else begin
      peer_busy_q <= peer_busy_d;
      sent_nr_q <= sent_nr_d;
      busy_prev_q <= local_busy_i;
      tx_ready_q <= tx_ready_d;
      tx_nr_q <= tx_nr_d;
      tx_dest_q <= tx_dest_d;
    end
  end

  assign peer_busy_o = peer_busy_q;
  assign tx_ready_pdu_o = tx_ready_q;
  assign tx_not_ready_resp_o = tx_nr_q;
  assign tx_dest_o = tx_dest_q;

  // pending acknowledged broadcast PDUs
  logic ack_resp;
  assign ack_resp = rx_ok && (kind == RX_ACK_READY_RESP || kind == RX_ACK_NOT_READY_RESP);

  for (genvar s = 0; s < SLOTS; s++) begin : g_slot
    logic valid_d, retire_d, hit;
    logic [ID_W-1:0] id_d;
    logic [PEERS-1:0] dest_d;
    assign hit = ack_resp && slot_valid_q[s] && slot_id_q[s] == rx_id_i;
    always_comb begin
      valid_d = slot_valid_q[s];
      id_d = slot_id_q[s];
      dest_d = slot_dest_q[s];
      retire_d = 1'b0;
      if (slot_load && load_sel == SLOT_W'(s)) begin
        id_d = avs_writedata_i[15:8];
        dest_d = avs_writedata_i[31:16];
        valid_d = avs_writedata_i[31:16] != '0;
      end else if (hit) begin
        // clearing an absent bit leaves the list unchanged
        dest_d[rx_src_i] = 1'b0;
        if (dest_d == '0) begin
          valid_d = 1'b0;
          retire_d = 1'b1;
        end
      end
    end
    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        slot_valid_q[s] <= 1'b0;
        slot_id_q[s] <= '0;
        slot_dest_q[s] <= '0;
        retire_q[s] <= 1'b0;
      end else begin
        slot_valid_q[s] <= valid_d;
        slot_id_q[s] <= id_d;
        slot_dest_q[s] <= dest_d;
        retire_q[s] <= retire_d;
      end
    end
  end

  assign pdu_retired_o = retire_q;

  // one-second tick and timers
  logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = tick_cnt_q == TICK_W'(TICK_CYCLES - 1);
    tick_cnt_d = tick_d ? '0 : tick_cnt_q + 1'b1;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  logic [NUM_TMR-1:0] tmr_start, tmr_stop;
  logic [TMR_W-1:0] tmr_load [NUM_TMR];
  assign tmr_start[TMR_ACK] = pdu_transmitted_i;
  assign tmr_stop[TMR_ACK] = ack_received_i;
  assign tmr_load[TMR_ACK] = ack_tmr_q;
  assign tmr_start[TMR_BUSY] = busy_start;
  assign tmr_stop[TMR_BUSY] = busy_stop;
  assign tmr_load[TMR_BUSY] = busy_tmr_q;
  assign tmr_start[TMR_TEST] = test_resp_queued_i;
  assign tmr_stop[TMR_TEST] = test_resp_sent_i;
  assign tmr_load[TMR_TEST] = test_ttl_q;

  for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
    logic [TMR_W-1:0] cnt_q, cnt_d;
    logic run_q, run_d, exp_d;
    always_comb begin
      cnt_d = cnt_q;
      run_d = run_q;
      exp_d = 1'b0;
      if (tmr_start[t]) begin
        cnt_d = tmr_load[t];
        run_d = tmr_load[t] != '0;
      end else if (tmr_stop[t]) begin
        run_d = 1'b0;
      end else if (run_q && tick_q) begin
        // granularity is one tick, so the wait ends up to one second early
        if (cnt_q == TMR_W'(1)) begin
          run_d = 1'b0;
          exp_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
    end
    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        cnt_q <= '0;
        run_q <= 1'b0;
        tmr_exp_q[t] <= 1'b0;
      end else begin
        cnt_q <= cnt_d;
        run_q <= run_d;
        tmr_exp_q[t] <= exp_d;
      end
    end
  end

  assign ack_timeout_o = tmr_exp_q[TMR_ACK];
  assign busy_timeout_o = tmr_exp_q[TMR_BUSY];
  assign test_resp_discard_o = tmr_exp_q[TMR_TEST];

  // interrupts
  logic [IRQ_W-1:0] irq_set;
  assign irq_set = {rx_valid_i & ~rx_ok, |retire_q, tmr_exp_q[TMR_TEST], tmr_exp_q[TMR_BUSY],
                    tmr_exp_q[TMR_ACK]};

  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr_en && avs_address_i == OFS_IRQ_STATUS) begin
      irq_stat_d = irq_stat_q & ~avs_writedata_i[IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | irq_set; // set wins over a same-cycle clear
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);
endmodule // link_ack_status

// >>> verification/link_ack_status_properties.sv
`timescale 1ns/1ps
module link_ack_status_chk
  import link_ack_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic rx_valid_i,
  input wire logic [2:0] rx_kind_i,
  input wire logic [link_ack_pkg::PEER_W-1:0] rx_src_i,
  input wire logic [link_ack_pkg::LEN_W-1:0] rx_len_i,
  input wire logic local_busy_i,
  input wire logic rx_accept_o,
  input wire logic tx_ready_pdu_o,
  input wire logic tx_not_ready_resp_o,
  input wire logic [link_ack_pkg::PEERS-1:0] peer_busy_o,
  input wire logic [link_ack_pkg::LEN_W-1:0] max_info_len_o,
  input wire logic [link_ack_pkg::SLOTS-1:0] pdu_retired_o,
  input wire logic ack_timeout_o,
  input wire logic busy_timeout_o,
  input wire logic test_resp_discard_o
);
  default clocking dcb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_wait_one: assert property (($rose(avs_read_i) || $rose(avs_write_i)) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus wait not one cycle");
  a_accept_len: assert property (rx_accept_o == (rx_valid_i && rx_len_i >= MIN_PDU_OCTETS
    && rx_len_i - PDU_OVERHEAD <= max_info_len_o)) else $error("accept decision wrong");
  a_info_range: assert property (max_info_len_o >= INFO_MIN && max_info_len_o <= INFO_MAX)
    else $error("max info out of range");
  a_busy_mark: assert property (rx_accept_o && rx_kind_i == RX_ACK_NOT_READY_CMD
    |=> peer_busy_o[$past(rx_src_i)]) else $error("peer not marked busy");
  a_busy_free: assert property (rx_accept_o && rx_kind_i == RX_ACK_READY_CMD |=> !peer_busy_o[$past(rx_src_i)])
    else $error("peer still busy");
  a_resp_excl: assert property (!(tx_ready_pdu_o && tx_not_ready_resp_o))
    else $error("ready and not ready together");
  a_nr_busy: assert property (tx_not_ready_resp_o |-> $past(local_busy_i))
    else $error("not ready response while idle");
  a_ack_pulse: assert property (ack_timeout_o |=> !ack_timeout_o [*8])
    else $error("ack expiry not single");
  a_busy_pulse: assert property ($rose(busy_timeout_o) |=> $fell(busy_timeout_o))
    else $error("busy expiry not single");
  a_test_pulse: assert property (test_resp_discard_o |=> !test_resp_discard_o)
    else $error("discard not single");
  a_retire_cause: assert property (|pdu_retired_o |-> $past(rx_valid_i) || $past(avs_write_i))
    else $error("retire without cause");
endmodule // link_ack_status_chk

bind link_ack_status link_ack_status_chk chk_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .rx_valid_i(rx_valid_i), .rx_kind_i(rx_kind_i), .rx_src_i(rx_src_i), .rx_len_i(rx_len_i),
  .local_busy_i(local_busy_i), .rx_accept_o(rx_accept_o), .tx_ready_pdu_o(tx_ready_pdu_o),
  .tx_not_ready_resp_o(tx_not_ready_resp_o), .peer_busy_o(peer_busy_o), .max_info_len_o(max_info_len_o),
  .pdu_retired_o(pdu_retired_o), .ack_timeout_o(ack_timeout_o), .busy_timeout_o(busy_timeout_o),
  .test_resp_discard_o(test_resp_discard_o));

// >>> verification/peer_station_model.sv
`timescale 1ns/1ps
module peer_station_model (
  input wire logic ref_clk_i,
  output logic rx_valid_o,
  output logic [2:0] rx_kind_o,
  output logic [link_ack_pkg::PEER_W-1:0] rx_src_o,
  output logic [link_ack_pkg::ID_W-1:0] rx_id_o,
  output logic [link_ack_pkg::LEN_W-1:0] rx_len_o
);
  import link_ack_pkg::*;
  initial begin
    rx_valid_o = 1'b0;
    {rx_kind_o, rx_src_o, rx_id_o, rx_len_o} = '1;
  end
  // one descriptor per call; fields inverted afterwards so stale values never look valid
  task automatic send(input logic [2:0] k, input logic [3:0] s, input logic [7:0] i, input logic [11:0] l);
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b1;
    {rx_kind_o, rx_src_o, rx_id_o, rx_len_o} <= {k, s, i, l};
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b0;
    {rx_kind_o, rx_src_o, rx_id_o, rx_len_o} <= ~{k, s, i, l};
  endtask
endmodule // peer_station_model

// >>> verification/tb_link_ack_status.sv
`timescale 1ns/1ps
module tb_link_ack_status;
  import link_ack_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic local_busy_i = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, irq_o, rx_valid_i, rx_accept_o, tx_ready_pdu_o, tx_not_ready_resp_o;
  logic ack_timeout_o, busy_timeout_o, test_resp_discard_o;
  logic [2:0] rx_kind_i;
  logic [3:0] rx_src_i, tx_dest_o, network_control_station_o, pdu_retired_o;
  logic [7:0] rx_id_i;
  logic [11:0] rx_len_i, max_info_len_o;
  logic [15:0] peer_busy_o;
  int mismatches = 0;
  int checks_done = 0;
  int n_rdy = 0, n_nrr = 0, n_ack = 0, n_bto = 0, n_tdr = 0, n_ret = 0, n_acc = 0;
  logic [7:0] cofs [4] = '{OFS_ACK_TMR, OFS_ACK_TMR, OFS_MAX_INFO, OFS_MAX_INFO};
  logic [31:0] cval [4] = '{32'h0000_0005, 32'h0000_07D0, 32'h0000_0FA0, 32'h0000_0064};
  logic [31:0] cexp [4] = '{32'h0000_000A, 32'h0000_0708, 32'h0000_0D11, 32'h0000_02C4};
  logic [7:0] rofs [5] = '{OFS_CTRL, OFS_MAX_INFO, OFS_BUSY_TMR, OFS_TEST_TTL, OFS_ACK_TMR};
  logic [31:0] rexp [5] = '{32'h0000_0000, 32'h0000_0D11, 32'h0000_0078, 32'h0000_0000, 32'h0000_0078};

  always #25 ref_clk_i = ~ref_clk_i;

  link_ack_status #(.TICK_CYCLES(20)) dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_o(irq_o), .rx_valid_i(rx_valid_i), .rx_kind_i(rx_kind_i), .rx_src_i(rx_src_i), .rx_id_i(rx_id_i),
    .rx_len_i(rx_len_i), .local_busy_i(local_busy_i), .not_ready_cmd_sent_i(ev[0]),
    .pdu_transmitted_i(ev[1]), .ack_received_i(ev[2]), .test_resp_queued_i(ev[3]), .test_resp_sent_i(ev[4]),
    .rx_accept_o(rx_accept_o), .tx_ready_pdu_o(tx_ready_pdu_o), .tx_not_ready_resp_o(tx_not_ready_resp_o),
    .tx_dest_o(tx_dest_o), .peer_busy_o(peer_busy_o), .network_control_station_o(network_control_station_o),
    .max_info_len_o(max_info_len_o), .pdu_retired_o(pdu_retired_o), .ack_timeout_o(ack_timeout_o),
    .busy_timeout_o(busy_timeout_o), .test_resp_discard_o(test_resp_discard_o));

  peer_station_model peer_u (.ref_clk_i(ref_clk_i), .rx_valid_o(rx_valid_i), .rx_kind_o(rx_kind_i),
    .rx_src_o(rx_src_i), .rx_id_o(rx_id_i), .rx_len_o(rx_len_i));

  always @(posedge ref_clk_i) begin
    n_rdy <= n_rdy + int'(tx_ready_pdu_o);
    n_nrr <= n_nrr + int'(tx_not_ready_resp_o);
    n_ack <= n_ack + int'(ack_timeout_o);
    n_bto <= n_bto + int'(busy_timeout_o);
    n_tdr <= n_tdr + int'(test_resp_discard_o);
    n_ret <= n_ret + int'(pdu_retired_o[0]);
    n_acc <= n_acc + int'(rx_accept_o);
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // the request is held until waitrequest is seen low at a rising edge
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    // only the watchdog ends a wait that never completes
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus_xfer(1'b1, a, wd, d);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_xfer(1'b0, a, 32'h0000_0000, d);
    chk(nm, d, exp);
  endtask

  task automatic pulse(input int b);
    @(posedge ref_clk_i);
    ev <= 5'(1 << b);
    @(posedge ref_clk_i);
    ev <= 5'h00;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    wait_cyc(5);
    rst_n_i <= 1'b1;
    for (int k = 0; k < 5; k++) rd_chk("reset value", rofs[k], rexp[k]);
    for (int k = 0; k < 4; k++) begin
      wr(cofs[k], cval[k]);
      rd_chk("clamped value", cofs[k], cexp[k]);
    end
    chk("max info port", 32'(max_info_len_o), 32'h0000_02C4);
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk("unmapped read", 8'h40, 32'h0000_0000);
    peer_u.send(RX_OTHER, 4'h1, 8'h00, 12'h02CD);
    peer_u.send(RX_OTHER, 4'h1, 8'h00, 12'h02CE);
    peer_u.send(RX_OTHER, 4'h1, 8'h00, 12'h0008);
    rd_chk("rx bad flag", OFS_IRQ_STATUS, 32'h0000_0010);
    chk("accepted count", n_acc, 1);
    chk("masked irq", 32'(irq_o), 0);
    wr(OFS_IRQ_STATUS, 32'h0000_001F);
    wr(OFS_IRQ_MASK, 32'h0000_0008);
    // slot 0 waits on peers 3 and 5 for id 5
    wr(OFS_SLOT_LOAD, 32'h0028_0500);
    peer_u.send(RX_ACK_NOT_READY_RESP, 4'h3, 8'h05, 12'h0009);
    peer_u.send(RX_ACK_NOT_READY_RESP, 4'h3, 8'h05, 12'h0009);
    peer_u.send(RX_ACK_READY_RESP, 4'h5, 8'h06, 12'h0009);
    wr(OFS_SLOT_VIEW, 32'h0000_0000);
    rd_chk("slot view", OFS_SLOT_VIEW, 32'h0020_0510);
    chk("retire early", n_ret, 0);
    peer_u.send(RX_ACK_READY_RESP, 4'h5, 8'h05, 12'h0009);
    rd_chk("slot valid", OFS_SLOT_LOAD, 32'h0000_0000);
    chk("retire count", n_ret, 1);
    chk("irq raised", 32'(irq_o), 1);
    wr(OFS_IRQ_STATUS, 32'h0000_0008);
    wait_cyc(1);
    chk("irq cleared", 32'(irq_o), 0);
    peer_u.send(RX_ACK_NOT_READY_CMD, 4'h2, 8'h00, 12'h0009);
    rd_chk("peer busy", OFS_PEER_BUSY, 32'h0000_0004);
    peer_u.send(RX_ACK_READY_CMD, 4'h2, 8'h00, 12'h0009);
    wait_cyc(2);
    chk("peer freed", 32'(peer_busy_o), 0);
    peer_u.send(RX_ACKED_BROADCAST_INFO, 4'h7, 8'h01, 12'h0009);
    wait_cyc(2);
    chk("ready sent", n_rdy, 1);
    chk("ready dest", 32'(tx_dest_o), 7);
    local_busy_i <= 1'b1;
    pulse(0);
    peer_u.send(RX_ACKED_BROADCAST_INFO, 4'h9, 8'h02, 12'h0009);
    wait_cyc(2);
    chk("not ready resp", n_nrr, 1);
    chk("no ready while busy", n_rdy, 1);
    local_busy_i <= 1'b0;
    wait_cyc(3);
    chk("busy exit ready", n_rdy, 2);
    wr(OFS_CTRL, 32'h0000_00A2);
    wait_cyc(2);
    chk("user ready", n_rdy, 3);
    chk("network_control_station dest", 32'(network_control_station_o), 32'h0000_000A);
    // silent must be in force before a user request can be refused
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0003);
    peer_u.send(RX_ACKED_BROADCAST_INFO, 4'h7, 8'h03, 12'h0009);
    wait_cyc(2);
    chk("silent mode", n_rdy, 3);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_BUSY_TMR, 32'h0000_0002);
    peer_u.send(RX_ACK_NOT_READY_CMD, 4'h4, 8'h00, 12'h0009);
    peer_u.send(RX_CONNECTIONLESS_NOT_READY, 4'h4, 8'h00, 12'h0009);
    wait_cyc(15);
    chk("busy timer early", n_bto, 0);
    wait_cyc(50);
    chk("busy timer expiry", n_bto, 1);
    chk("busy cleared", 32'(peer_busy_o), 0);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_TEST_TTL, 32'(k));
      pulse(3);
      if (k == 2) pulse(4);
      wait_cyc(80);
      chk("test discards", n_tdr, int'(k > 0));
    end
    wr(OFS_ACK_TMR, 32'h0000_0005);
    wait_cyc(100);
    chk("ack idle", n_ack, 0);
    pulse(1);
    wait_cyc(150);
    chk("ack early", n_ack, 0);
    wait_cyc(100);
    chk("ack expiry", n_ack, 1);
    pulse(1);
    pulse(2);
    wait_cyc(250);
    chk("ack stopped", n_ack, 1);
    wrap_up();
  end

  initial begin
    wait_cyc(6000);
    mismatches++;
    wrap_up();
  end
endmodule // tb_link_ack_status
